// file: cfc_card_model.sv
// card-side model: decodes reader frames (miller, nrz, manchester) and answers with manchester replies
// assumes bit_div holds the reader bit period in clk cycles while a frame is sent
`timescale 1ns/1ps
module cfc_card_model (
  input wire logic clk,
  input wire logic tx_mod,
  input wire logic tx_busy,
  input wire logic [7:0] bit_div,
  input wire logic [1:0] proto,
  input wire logic par9,
  output logic rx_in
);
  int bpos;
  logic v;
  logic [7:0] got_q[$];
  int cnt;
  int nbits;
  int viol;
  logic first_half;
  logic pol;
  logic busy_d;
  logic [7:0] shf;

  initial
  begin
    rx_in = 1'b0;
    busy_d = 1'b0;
    cnt = 0;
    nbits = 0;
    viol = 0;
    bpos = 0;
  end

  // half-bit sampling; polarity taken from the first preamble bit, which is a zero
  always @(posedge clk)
  begin
    busy_d <= tx_busy;
    if (tx_busy && !busy_d)
    begin
      cnt = 0;
      nbits = 0;
      viol = 0;
      bpos = 0;
      got_q.delete();
    end
    else if (tx_busy)
      cnt++;
    if (tx_busy && (cnt % int'(bit_div)) == int'(bit_div) / 4)
      first_half = tx_mod;
    if (tx_busy && (cnt % int'(bit_div)) == 3 * int'(bit_div) / 4)
    begin
      if (nbits == 0)
        pol = first_half;
      // A: pause late in the bit means 1; B: keyed means 0; J: first half level
      case (proto)
        2'h0: v = tx_mod;
        2'h1: v = !tx_mod;
        default: v = first_half ^ pol;
      endcase
      if (proto == 2'h2 && tx_mod === first_half && got_q.size() < 8)
        viol++;
      if (bpos < 8)
        shf = (proto == 2'h2) ? {shf[6:0], v} : {v, shf[7:1]};
      if (bpos == 7)
        got_q.push_back(shf);
      if (bpos == 8 && v !== ~^shf)
        viol++;
      bpos = (bpos == (par9 ? 8 : 7)) ? 0 : bpos + 1;
      nbits++;
    end
  end

  // reply: preamble and sync, then the given bytes, msb first, manchester, idle low after
  task automatic send_reply(input logic [7:0] q[$], input int div);
    int b;
    logic [7:0] fr[$];
    fr = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, cfc_pkg::CFC_SYNC0, cfc_pkg::CFC_SYNC1};
    fr = {fr, q};
    foreach (fr[i])
    begin
      for (b = 7; b >= 0; b--)
      begin
        rx_in = fr[i][b];
        repeat (div / 2) @(posedge clk);
        #1;
        rx_in = ~fr[i][b];
        repeat (div / 2) @(posedge clk);
        #1;
      end
    end
    rx_in = 1'b0;
  endtask : send_reply
endmodule : cfc_card_model

// file: cfc_coder.sv
// contactless frame coder: framing, crc, parity and bit coding toward the card,
// bit decoding of card replies toward the host, with deframing in JIS mode only.
// assumes clk is the carrier fc; rx_in is the demodulated subcarrier/load level from the analog front end.
// Behaviour
// - type A transmit uses modified Miller, a pause per bit except for a 0 after a 1, period fc/128..fc/16
// - type A receive: fc/16 subcarrier, Manchester at 106, BPSK above
// - type A frames carry the part 3 CRC computed internally
// - type A adds odd parity per byte; dropped at speeds above 106
// - type B sends NRZ with 10 percent keying, receives BPSK fc/16
// - JIS mode Manchester-codes at fc/64 or fc/32 and decodes Manchester replies
// - JIS frames start with six zero bytes then B2h, 4Dh automatically
// - length byte counts data bytes plus itself
// - JIS CRC is computed most significant bit first
// - JIS CRC is appended after the last data byte
`timescale 1ns/1ps
module cfc_coder (
  input wire logic clk,
  input wire logic rst,
  input wire cfc_pkg::cfc_cfg_t cfg,
  input wire cfc_pkg::cfc_byte_t tx_byte,
  output logic tx_ready,
  output logic tx_mod,
  output logic tx_keying_full,
  output logic tx_busy,
  input wire logic rx_in,
  output cfc_pkg::cfc_rx_byte_t rx_byte
);

  typedef enum logic [2:0] {
    CFC_TX_IDLE = 3'b000,
    CFC_TX_PRE = 3'b001,
    CFC_TX_DATA = 3'b010,
    CFC_TX_CRC = 3'b011,
    CFC_TX_EOF = 3'b100
  } cfc_txst_t;

  // speed code to bit period in carrier cycles
  function automatic logic [7:0] cfc_div(input logic [1:0] sp);
    case (sp)
      2'b00: cfc_div = cfc_pkg::CFC_DIV_106;
      2'b01: cfc_div = cfc_pkg::CFC_DIV_212;
      2'b10: cfc_div = cfc_pkg::CFC_DIV_424;
      default: cfc_div = cfc_pkg::CFC_DIV_848;
    endcase
  endfunction : cfc_div

  // one crc bit step; reflected poly for type A/B, msb-first for JIS
  function automatic logic [15:0] cfc_crc_bit(input logic [15:0] c, input logic b, input logic msb);
    if (msb)
      cfc_crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? cfc_pkg::CFC_CRC_J_POLY : 16'h0000);
    else
      cfc_crc_bit = {1'b0, c[15:1]} ^ ((c[0] ^ b) ? cfc_pkg::CFC_CRC_A_POLY : 16'h0000);
  endfunction : cfc_crc_bit

  function automatic logic [15:0] cfc_crc_init(input cfc_pkg::cfc_proto_t p);
    case (p)
      cfc_pkg::CFC_PROTO_A: cfc_crc_init = cfc_pkg::CFC_CRC_A_INIT;
      cfc_pkg::CFC_PROTO_B: cfc_crc_init = cfc_pkg::CFC_CRC_B_INIT;
      default: cfc_crc_init = cfc_pkg::CFC_CRC_J_INIT;
    endcase
  endfunction : cfc_crc_init

  // ---------------- transmit ----------------
  cfc_txst_t tst_reg, tst_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [3:0] bcnt_reg, bcnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [15:0] crc_reg, crc_next;
  logic last_reg, last_next;
  logic par_reg, par_next;
  logic prev_reg, prev_next;
  logic mod_reg, mod_next;
  logic rdy_reg, rdy_next;
  logic full_reg, full_next;
  logic [7:0] div;
  logic msb_first;
  logic [3:0] nbits;
  logic cur_bit;
  logic [15:0] crc_upd;
  logic [15:0] crc_fin;
  logic [7:0] crc_byte;
  logic busy_reg, busy_next;

  always_comb
  begin
    div = cfc_div(cfg.speed);
    if (cfg.proto == cfc_pkg::CFC_PROTO_J)
      div = cfg.speed[1] ? cfc_pkg::CFC_DIV_424 : cfc_pkg::CFC_DIV_212;
    msb_first = (cfg.proto == cfc_pkg::CFC_PROTO_J);
    // 8 data bits plus parity only for type A at 106
    nbits = (cfg.proto == cfc_pkg::CFC_PROTO_A && cfg.speed == 2'b00) ? 4'h9 : 4'h8;
    if (bit_reg == 4'h8)
      cur_bit = par_reg;
    else
      cur_bit = msb_first ? sh_reg[7] : sh_reg[0];
    // crc including the bit now ending, so the last data bit reaches the appended bytes
    crc_upd = crc_reg;
    if (tst_reg == CFC_TX_DATA && bit_reg < 4'h8)
      crc_upd = cfc_crc_bit(crc_reg, cur_bit, msb_first);
    crc_fin = (cfg.proto == cfc_pkg::CFC_PROTO_B) ? ~crc_upd : crc_upd;
    crc_byte = msb_first ? crc_fin[15:8] : crc_fin[7:0];
  end

  always_comb
  begin
    tst_next = tst_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    bcnt_next = bcnt_reg;
    sh_next = sh_reg;
    crc_next = crc_reg;
    last_next = last_reg;
    par_next = par_reg;
    prev_next = prev_reg;
    mod_next = mod_reg;
    rdy_next = 1'b0;
    full_next = (cfg.proto == cfc_pkg::CFC_PROTO_A);
    case (tst_reg)
      CFC_TX_IDLE:
      begin
        mod_next = 1'b0;
        prev_next = 1'b0;
        crc_next = cfc_crc_init(cfg.proto);
        cnt_next = 8'h00;
        bit_next = 4'h0;
        if (tx_byte.valid)
        begin
          // JIS preamble and sync come from here, never from the host
          if (cfg.proto == cfc_pkg::CFC_PROTO_J)
          begin
            tst_next = CFC_TX_PRE;
            bcnt_next = 4'h0;
            sh_next = 8'h00;
          end
          else
          begin
            tst_next = CFC_TX_DATA;
            sh_next = tx_byte.data;
            last_next = tx_byte.last;
            par_next = ~^tx_byte.data;
            rdy_next = 1'b1;
          end
        end
      end
      CFC_TX_PRE, CFC_TX_DATA, CFC_TX_CRC:
      begin
        cnt_next = cnt_reg + 8'h01;
        // per-protocol line coding of the current bit
        case (cfg.proto)
          cfc_pkg::CFC_PROTO_A: // pause for 1 at half-bit, for 0 after 0 in first quarter
            mod_next = (cur_bit && cnt_reg >= (div >> 1) && cnt_reg < (div >> 1) + (div >> 2))
              || (!cur_bit && !prev_reg && cnt_reg < (div >> 2));
          cfc_pkg::CFC_PROTO_B:
            mod_next = !cur_bit;
          default:
            mod_next = (cnt_reg < (div >> 1)) ? cur_bit : !cur_bit;
        endcase
        if (cnt_reg == div - 8'h01)
        begin
          cnt_next = 8'h00;
          prev_next = cur_bit;
          bit_next = bit_reg + 4'h1;
          crc_next = crc_upd;
          if (bit_reg < 4'h8)
            sh_next = msb_first ? {sh_reg[6:0], 1'b0} : {1'b0, sh_reg[7:1]};
          if (bit_reg == nbits - 4'h1)
          begin
            bit_next = 4'h0;
            bcnt_next = bcnt_reg + 4'h1;
            if (tst_reg == CFC_TX_PRE)
            begin
              if (bcnt_reg == cfc_pkg::CFC_PREAMBLE_LEN - 4'h1)
                sh_next = cfc_pkg::CFC_SYNC0;
              else if (bcnt_reg == cfc_pkg::CFC_PREAMBLE_LEN)
                sh_next = cfc_pkg::CFC_SYNC1;
              else if (bcnt_reg == cfc_pkg::CFC_PREAMBLE_LEN + 4'h1)
              begin
                // first host byte is the length byte
                tst_next = CFC_TX_DATA;
                sh_next = tx_byte.data;
                last_next = tx_byte.last;
                par_next = ~^tx_byte.data;
                rdy_next = 1'b1;
              end
              else
                sh_next = 8'h00;
            end
            else if (tst_reg == CFC_TX_DATA && !last_reg)
            begin
              // next host byte must be ready; an underrun ends the frame
              sh_next = tx_byte.data;
              last_next = tx_byte.last || !tx_byte.valid;
              par_next = ~^tx_byte.data;
              rdy_next = tx_byte.valid;
              if (!tx_byte.valid)
                tst_next = CFC_TX_EOF;
            end
            else if (tst_reg == CFC_TX_DATA)
            begin
              tst_next = CFC_TX_CRC;
              bcnt_next = 4'h0;
              sh_next = crc_byte;
              par_next = ~^crc_byte;
            end
            else if (bcnt_reg == 4'h0)
            begin
              sh_next = msb_first ? crc_fin[7:0] : crc_fin[15:8];
              par_next = ~^sh_next;
            end
            else
              tst_next = CFC_TX_EOF;
          end
        end
      end
      CFC_TX_EOF:
      begin
        mod_next = 1'b0;
        tst_next = CFC_TX_IDLE;
      end
      default:
        tst_next = CFC_TX_IDLE;
    endcase
    busy_next = (tst_next != CFC_TX_IDLE);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tst_reg <= CFC_TX_IDLE;
      cnt_reg <= 8'h00;
      bit_reg <= 4'h0;
      bcnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      crc_reg <= 16'h0000;
      last_reg <= 1'b0;
      par_reg <= 1'b0;
      prev_reg <= 1'b0;
      mod_reg <= 1'b0;
      rdy_reg <= 1'b0;
      full_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      tst_reg <= tst_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      bcnt_reg <= bcnt_next;
      sh_reg <= sh_next;
      crc_reg <= crc_next;
      last_reg <= last_next;
      par_reg <= par_next;
      prev_reg <= prev_next;
      mod_reg <= mod_next;
      rdy_reg <= rdy_next;
      full_reg <= full_next;
      busy_reg <= busy_next;
    end
  end

  assign tx_ready = rdy_reg;
  assign tx_mod = mod_reg;
  assign tx_keying_full = full_reg;
  assign tx_busy = busy_reg;

  // ---------------- receive ----------------
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
  logic [7:0] rcnt_reg, rcnt_next;
  logic [7:0] rsh_reg, rsh_next;
  logic [2:0] rbit_reg, rbit_next;
  logic [3:0] rby_reg, rby_next;
  logic [7:0] rlen_reg, rlen_next;
  logic [15:0] rcrc_reg, rcrc_next;
  logic ract_reg, ract_next;
  logic rph_reg, rph_next;
  cfc_pkg::cfc_rx_byte_t rxo_reg, rxo_next;
  logic sample, rbit_val;
  logic [7:0] rdiv;
  logic [7:0] rbyte_new;

  always_comb
  begin
    rdiv = (cfg.proto == cfc_pkg::CFC_PROTO_J) ? (cfg.speed[1] ? cfc_pkg::CFC_DIV_424 : cfc_pkg::CFC_DIV_212)
      : cfc_div(cfg.speed);
    sample = (rcnt_reg == (rdiv >> 2)) || (rcnt_reg == (rdiv >> 1) + (rdiv >> 2));
    // Manchester: first half level is the bit; BPSK: first half level xor second half level
    if (cfg.proto == cfc_pkg::CFC_PROTO_J || (cfg.proto == cfc_pkg::CFC_PROTO_A && cfg.speed == 2'b00))
      rbit_val = rph_reg;
    else
      rbit_val = rph_reg ^ rx_s3_reg;
    rbyte_new = msb_first ? {rsh_reg[6:0], rbit_val} : {rbit_val, rsh_reg[7:1]};
    rcnt_next = (rcnt_reg == rdiv - 8'h01) ? 8'h00 : rcnt_reg + 8'h01;
    rsh_next = rsh_reg;
    rbit_next = rbit_reg;
    rby_next = rby_reg;
    rlen_next = rlen_reg;
    rcrc_next = rcrc_reg;
    ract_next = ract_reg;
    rph_next = rph_reg;
    rxo_next = '0;
    if (!ract_reg)
    begin
      rcnt_next = 8'h00;
      rby_next = 4'h0;
      rbit_next = 3'h0;
      rcrc_next = cfc_crc_init(cfg.proto);
      if (rx_s3_reg != rx_s2_reg)
      begin
        ract_next = 1'b1;
        // a jis reply opens with preamble zeros, low first half, so the first edge is mid-bit
        if (cfg.proto == cfc_pkg::CFC_PROTO_J)
        begin
          rcnt_next = rdiv >> 1;
          rph_next = 1'b0;
        end
      end
    end
    else if (sample && rcnt_reg == (rdiv >> 2))
      rph_next = rx_s3_reg;
    else if (sample)
    begin
      rsh_next = rbyte_new;
      rbit_next = rbit_reg + 3'h1;
      if (!(cfg.proto == cfc_pkg::CFC_PROTO_J && rby_reg < cfc_pkg::CFC_PREAMBLE_LEN + 4'h2))
        rcrc_next = cfc_crc_bit(rcrc_reg, rbit_val, msb_first);
      if (rbit_reg == 3'h7)
      begin
        rby_next = (rby_reg == 4'hF) ? rby_reg : rby_reg + 4'h1;
        // preamble zeros and sync bytes are swallowed in JIS mode
        if (cfg.proto == cfc_pkg::CFC_PROTO_J && rby_reg < cfc_pkg::CFC_PREAMBLE_LEN + 4'h2)
        begin
          if (rby_reg == cfc_pkg::CFC_PREAMBLE_LEN + 4'h1 && rbyte_new != cfc_pkg::CFC_SYNC1)
            ract_next = 1'b0;
        end
        else
        begin
          if (cfg.proto == cfc_pkg::CFC_PROTO_J && rby_reg == cfc_pkg::CFC_PREAMBLE_LEN + 4'h2)
            // length counts itself; its data bytes and two crc bytes follow
            rlen_next = rbyte_new + 8'h01;
          else
            rlen_next = rlen_reg - 8'h01;
          rxo_next.valid = 1'b1;
          rxo_next.data = rbyte_new;
          rxo_next.last = (cfg.proto == cfc_pkg::CFC_PROTO_J && rlen_reg == 8'h01);
          rxo_next.crc_ok = (rcrc_next == 16'h0000) || (cfg.proto != cfc_pkg::CFC_PROTO_J);
          if (rxo_next.last)
            ract_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_s1_reg <= 1'b0;
      rx_s2_reg <= 1'b0;
      rx_s3_reg <= 1'b0;
      rcnt_reg <= 8'h00;
      rsh_reg <= 8'h00;
      rbit_reg <= 3'h0;
      rby_reg <= 4'h0;
      rlen_reg <= 8'h00;
      rcrc_reg <= 16'h0000;
      ract_reg <= 1'b0;
      rph_reg <= 1'b0;
      rxo_reg <= '0;
    end
    else
    begin
      rx_s1_reg <= rx_in;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      rcnt_reg <= rcnt_next;
      rsh_reg <= rsh_next;
      rbit_reg <= rbit_next;
      rby_reg <= rby_next;
      rlen_reg <= rlen_next;
      rcrc_reg <= rcrc_next;
      ract_reg <= ract_next;
      rph_reg <= rph_next;
      rxo_reg <= rxo_next;
    end
  end

  assign rx_byte = rxo_reg;

  // ---------------- checks ----------------
  AST_J_PREAMBLE: assert property (@(posedge clk) disable iff (rst)
    (tst_reg == CFC_TX_IDLE && tx_byte.valid && cfg.proto == cfc_pkg::CFC_PROTO_J) |=> tst_reg == CFC_TX_PRE && !tx_ready)
    else $error("jis frame did not begin with preamble");
  AST_CRC_AFTER_DATA: assert property (@(posedge clk) disable iff (rst)
    (tst_reg == CFC_TX_CRC) |-> $past(tst_reg) inside {CFC_TX_DATA, CFC_TX_CRC})
    else $error("crc sent without data before it");
  AST_A_FULL: assert property (@(posedge clk) disable iff (rst)
    (cfg.proto == cfc_pkg::CFC_PROTO_A && $stable(cfg)) |=> tx_keying_full)
    else $error("type A not using full keying");
  AST_B_TEN: assert property (@(posedge clk) disable iff (rst)
    (cfg.proto == cfc_pkg::CFC_PROTO_B && $stable(cfg)) |=> !tx_keying_full)
    else $error("type B using full keying");
  AST_B_NRZ: assert property (@(posedge clk) disable iff (rst)
    (cfg.proto == cfc_pkg::CFC_PROTO_B && tst_reg == CFC_TX_DATA) |=> tx_mod == !$past(cur_bit))
    else $error("type B not NRZ");
  AST_PARITY_ODD: assert property (@(posedge clk) disable iff (rst)
    tx_ready |-> par_reg == ~^sh_reg)
    else $error("parity not odd");
  AST_NBITS: assert property (@(posedge clk) disable iff (rst)
    (tst_reg != CFC_TX_IDLE && !(cfg.proto == cfc_pkg::CFC_PROTO_A && cfg.speed == 2'b00)) |-> bit_reg < 4'h8)
    else $error("parity bit sent outside type A 106");
  AST_J_MANCH: assert property (@(posedge clk) disable iff (rst)
    (cfg.proto == cfc_pkg::CFC_PROTO_J && tst_reg == CFC_TX_DATA && cnt_reg == 8'h01) |=> tx_mod == $past(cur_bit))
    else $error("jis first half not the bit value");
  AST_RX_OUT_SYNC: assert property (@(posedge clk) disable iff (rst)
    (rx_byte.valid && cfg.proto == cfc_pkg::CFC_PROTO_J) |-> $past(rby_reg, 1) >= cfc_pkg::CFC_PREAMBLE_LEN + 4'h2)
    else $error("preamble or sync passed to host");
  CVR_J_FRAME: cover property (@(posedge clk) tst_reg == CFC_TX_CRC && cfg.proto == cfc_pkg::CFC_PROTO_J);
  CVR_A_FRAME: cover property (@(posedge clk) tst_reg == CFC_TX_EOF && cfg.proto == cfc_pkg::CFC_PROTO_A);
  CVR_RX_LAST: cover property (@(posedge clk) rx_byte.valid && rx_byte.last);

endmodule : cfc_coder

// file: cfc_pkg.sv
// contactless frame coder package: modes, speeds, framing constants and carrier structs
// assumes the fc carrier clock (or a stand-in) drives clk; all counts are in clk cycles
package cfc_pkg;

  typedef enum logic [1:0] {
    CFC_PROTO_A = 2'b00,
    CFC_PROTO_B = 2'b01,
    CFC_PROTO_J = 2'b10
  } cfc_proto_t;

  // speed code 0..3 = 106, 212, 424, 848 kbit/s for types A and B; JIS gives 212 for codes 0..1, 424 for 2..3
  localparam logic [7:0] CFC_DIV_106 = 8'h80;
  localparam logic [7:0] CFC_DIV_212 = 8'h40;
  localparam logic [7:0] CFC_DIV_424 = 8'h20;
  localparam logic [7:0] CFC_DIV_848 = 8'h10;
  localparam logic [7:0] CFC_SUBC_DIV = 8'h10;

  localparam logic [3:0] CFC_PREAMBLE_LEN = 4'h6;
  localparam logic [7:0] CFC_SYNC0 = 8'hB2;
  localparam logic [7:0] CFC_SYNC1 = 8'h4D;
  localparam logic [15:0] CFC_CRC_A_INIT = 16'h6363;
  localparam logic [15:0] CFC_CRC_A_POLY = 16'h8408;
  localparam logic [15:0] CFC_CRC_J_INIT = 16'h0000;
  localparam logic [15:0] CFC_CRC_J_POLY = 16'h1021;
  localparam logic [15:0] CFC_CRC_B_INIT = 16'hFFFF;

  typedef struct packed {
    cfc_proto_t proto;
    logic [1:0] speed;
  } cfc_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } cfc_byte_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic crc_ok;
    logic par_err;
  } cfc_rx_byte_t;

endpackage : cfc_pkg

// file: contactless_frame_coder_tb.sv
// testbench for the frame coder: frames in all modes and speeds, random except 00h FFh for A and B at 106, card model on the rf side
// assumes a 5 ns clock stands in for the carrier and the design asserts its own rules internally
`timescale 1ns/1ps
module contactless_frame_coder_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cfc_pkg::cfc_cfg_t cfg = '0;
  cfc_pkg::cfc_byte_t tx_byte = '0;
  logic tx_ready;
  logic tx_mod;
  logic tx_keying_full;
  logic tx_busy;
  logic rx_in;
  cfc_pkg::cfc_rx_byte_t rx_byte;
  logic [7:0] bit_div = 8'h40;
  cfc_pkg::cfc_rx_byte_t rxq[$];
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int busy_cnt;
  int ready_cnt;
  int keying_err;

  always #2.5 clk = ~clk;

  cfc_coder dut_u (.clk(clk), .rst(rst), .cfg(cfg), .tx_byte(tx_byte), .tx_ready(tx_ready), .tx_mod(tx_mod),
    .tx_keying_full(tx_keying_full), .tx_busy(tx_busy), .rx_in(rx_in), .rx_byte(rx_byte));
  cfc_card_model card_u (.clk(clk), .tx_mod(tx_mod), .tx_busy(tx_busy), .bit_div(bit_div), .proto(cfg.proto),
    .par9(cfg.proto == cfc_pkg::CFC_PROTO_A && cfg.speed == 2'h0), .rx_in(rx_in));

  always @(posedge clk)
  begin
    cycles++;
    if (rx_byte.valid === 1'b1)
      rxq.push_back(rx_byte);
    if (tx_ready === 1'b1)
      ready_cnt++;
    if (tx_busy === 1'b1)
    begin
      busy_cnt++;
      if (tx_keying_full !== (cfg.proto == cfc_pkg::CFC_PROTO_A))
        keying_err++;
    end
    if (cycles == 95000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  function automatic logic [15:0] crc_msb(input logic [7:0] q[$]);
    logic [15:0] c;
    c = cfc_pkg::CFC_CRC_J_INIT;
    foreach (q[i])
      for (int b = 7; b >= 0; b--)
        c = ((c[15] ^ q[i][b]) == 1'b1) ? ((c << 1) ^ cfc_pkg::CFC_CRC_J_POLY) : (c << 1);
    return c;
  endfunction : crc_msb

  function automatic logic [15:0] crc_lsb(input logic [7:0] q[$], input logic [15:0] init);
    logic [15:0] c;
    c = init;
    foreach (q[i])
      for (int b = 0; b < 8; b++)
        c = ((c[0] ^ q[i][b]) == 1'b1) ? ((c >> 1) ^ cfc_pkg::CFC_CRC_A_POLY) : (c >> 1);
    return c;
  endfunction : crc_lsb

  function automatic int div_of(input logic [1:0] s);
    case (s)
      2'h0: return int'(cfc_pkg::CFC_DIV_106);
      2'h1: return int'(cfc_pkg::CFC_DIV_212);
      2'h2: return int'(cfc_pkg::CFC_DIV_424);
      default: return int'(cfc_pkg::CFC_DIV_848);
    endcase
  endfunction : div_of

  // host side: only length and data bytes are offered, each held until tx_ready
  task automatic send_frame(input logic [7:0] q[$]);
    int i;
    int w;
    busy_cnt = 0;
    ready_cnt = 0;
    keying_err = 0;
    i = 0;
    tx_byte = {1'b1, q[0], q.size() == 1};
    while (i < q.size())
    begin
      w = 0;
      do
      begin
        @(posedge clk);
        w++;
      end while (tx_ready !== 1'b1 && w < 20000);
      #1;
      i++;
      if (w >= 20000)
      begin
        check("tx_ready wait", 32'h1, 32'h0);
        i = q.size();
      end
      if (i < q.size())
        tx_byte = {1'b1, q[i], i == q.size() - 1};
      else
        tx_byte = '0;
    end
    w = 0;
    while (tx_busy !== 1'b0 && w < 40000)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    check("tx_busy end", 32'h0, {31'h0, tx_busy});
    repeat (20) @(posedge clk);
    #1;
  endtask : send_frame

  task automatic j_transmit(input logic [1:0] s, input int n);
    logic [7:0] q[$];
    logic [15:0] c;
    cfg = {cfc_pkg::CFC_PROTO_J, s};
    bit_div = s[1] ? 8'h20 : 8'h40;
    q = {8'(n + 1)};
    for (int i = 0; i < n; i++)
      q.push_back(8'($urandom));
    c = crc_msb(q);
    send_frame(q);
    check("got bytes", 32'h1, {31'h0, card_u.got_q.size() >= 10 + n + 1});
    if (card_u.got_q.size() >= 10 + n + 1)
    begin
      for (int i = 0; i < 6; i++)
        check("preamble", 32'h0, {24'h0, card_u.got_q[i]});
      check("sync0", {24'h0, cfc_pkg::CFC_SYNC0}, {24'h0, card_u.got_q[6]});
      check("sync1", {24'h0, cfc_pkg::CFC_SYNC1}, {24'h0, card_u.got_q[7]});
      foreach (q[i])
        check("len data", {24'h0, q[i]}, {24'h0, card_u.got_q[8 + i]});
      check("crc", {16'h0, c}, {16'h0, card_u.got_q[9 + n], card_u.got_q[10 + n]});
    end
    check("manchester", 32'h0, card_u.viol);
    check("keying", 32'h0, keying_err);
  endtask : j_transmit

  task automatic j_receive(input int n, input logic bad);
    logic [7:0] q[$];
    logic [15:0] c;
    int k;
    cfg = {cfc_pkg::CFC_PROTO_J, 2'h0};
    q = {8'(n + 1)};
    for (int i = 0; i < n; i++)
      q.push_back(8'($urandom));
    c = crc_msb(q) ^ {15'h0, bad};
    q = {q, c[15:8], c[7:0]};
    rxq.delete();
    card_u.send_reply(q, 64);
    // long enough for a receive restarted by the trailing edge to give up before the next reply
    repeat (5000) @(posedge clk);
    #1;
    check("rx count", 32'(n + 3), rxq.size());
    for (int i = 0; i < n + 3 && i < rxq.size(); i++)
      check("rx data", {24'h0, q[i]}, {24'h0, rxq[i].data});
    k = -1;
    foreach (rxq[i])
      if (rxq[i].last === 1'b1 && k < 0)
        k = i;
    check("rx last", 32'(n + 2), k);
    if (k >= 0)
      check("rx crc_ok", {31'h0, !bad}, {31'h0, rxq[k].crc_ok});
  endtask : j_receive

  initial
  begin
    logic [7:0] q[$];
    int d;
    int nb;
    logic [15:0] c;
    void'($urandom(32'h7f5ca61f));
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    check("reset outputs", 32'h0, {27'h0, tx_mod, tx_ready, tx_busy, tx_keying_full, |rx_byte});
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 4; s++)
      begin
        cfg = {p == 0 ? cfc_pkg::CFC_PROTO_A : cfc_pkg::CFC_PROTO_B, 2'(s)};
        q = (s == 0) ? {8'h00, 8'hFF} : {8'($urandom), 8'($urandom)};
        d = div_of(2'(s));
        nb = 2 * ((p == 0 && s == 0) ? 9 : 8) + 16;
        bit_div = 8'(d);
        send_frame(q);
        check("ready count", 32'h2, ready_cnt);
        check("frame bytes", 32'h4, card_u.got_q.size());
        c = (p == 0) ? crc_lsb(q, cfc_pkg::CFC_CRC_A_INIT) : ~crc_lsb(q, cfc_pkg::CFC_CRC_B_INIT);
        if (card_u.got_q.size() == 4)
        begin
          check("bytes sent", {16'h0, q[0], q[1]}, {16'h0, card_u.got_q[0], card_u.got_q[1]});
          check("crc sent", {16'h0, c}, {16'h0, card_u.got_q[3], card_u.got_q[2]});
        end
        check("parity", 32'h0, card_u.viol);
        check("keying", 32'h0, keying_err);
        check("frame min", 32'h1, {31'h0, busy_cnt >= nb * d});
        check("frame max", 32'h1, {31'h0, busy_cnt <= (2 * 10 + 60) * d});
      end
    j_transmit(2'h0, 4);
    j_transmit(2'h2, 1);
    j_receive(3, 1'b0);
    j_receive(2, 1'b1);
    summarize();
  end
endmodule : contactless_frame_coder_tb
